// *** dece_diag_check.v ***
// Purpose: error-check enable register and the checks it arms
// Assumes: serial decoder on clk_i presents each request before chip select rises
// Notes: flags are sticky, set beats clear, and clear comes from the error register
`timescale 1ns/1ps
`include "dece_regs.vh"

module dece_diag_check
#(
    parameter [13:0] MAP_PERIOD_CYC = `DECE_MAP_PERIOD_CYC
)
(
    // clock and reset
    input wire clk_i,
    input wire resetn_i,
    // serial pins, asynchronous to clk_i
    input wire spi_sclk_i,
    input wire spi_cs_n_i,
    // control register bits
    input wire chip_select_required_i,
    input wire streaming_read_i,
    // decoded request from the serial decoder
    input wire req_valid_i,
    input wire req_write_i,
    input wire [5:0] req_addr_i,
    input wire [23:0] req_wdata_i,
    input wire [5:0] req_len_i,
    input wire req_addr_ok_i,
    input wire req_addr_ro_i,
    input wire req_crc_ok_i,
    // device activity
    input wire fuse_copy_busy_i,
    input wire calib_busy_i,
    input wire calib_done_i,
    input wire seq_idle_i,
    input wire adc_check_fail_i,
    input wire rom_check_done_i,
    input wire rom_check_fail_i,
    // map scan port
    output reg [5:0] map_rd_idx_o,
    input wire [23:0] map_rd_data_i,
    input wire map_rd_writable_i,
    // committed register write
    output reg wr_commit_o,
    output reg [5:0] wr_addr_o,
    output reg [23:0] wr_data_o,
    // enable register and flags
    output reg [15:0] err_en_o,
    input wire [7:0] err_clear_i,
    output reg [7:0] err_flags_o
);

    // pin synchronisers and filtered levels
    reg [2:0] sclk_sync; // sclk stages, [0] first
    reg [2:0] cs_sync; // chip select stages
    reg sclk_f; // agreed sclk level
    reg cs_f; // agreed chip select level
    reg sclk_d; // sclk level one cycle back
    reg cs_d; // chip select one cycle back
    wire sclk_rise; // serial clock edge
    wire cs_fall; // frame start
    wire cs_rise; // frame end

    // frame bookkeeping
    reg [5:0] bit_cnt; // serial clocks in this frame
    reg req_pend; // request waiting for frame end
    reg req_wr; // latched direction
    reg [5:0] req_addr; // latched address
    reg [23:0] req_data; // latched write data
    reg [5:0] req_len; // latched expected bit count
    reg req_ok; // latched address valid
    reg req_ro; // latched read-only
    reg req_crc; // latched checksum good

    // decision terms
    wire cnt_armed; // clock count check live
    wire busy; // writes currently ignored
    wire short_frame; // too few serial clocks
    wire wr_end; // write frame finishing
    wire rd_end; // read frame finishing
    wire commit; // write goes through
    wire map_change; // legitimate map update
    reg [7:0] set_vec; // flag set requests
    reg stream_d; // streaming read one cycle back

    // map scan state
    reg [1:0] st; // scan state
    reg [13:0] per_cnt; // period counter
    reg ref_req; // reference rebuild pending
    reg chk_req; // compare pending
    reg scan_ref; // current scan builds reference
    reg issuing; // indices still being issued
    reg dv; // read data valid this cycle
    reg [7:0] crc; // running scan crc
    reg [7:0] ref_crc; // stored reference
    reg ref_valid; // reference exists
    wire [7:0] crc_next; // crc after this word
    wire map_fault; // compare mismatch
    wire ref_take; // reference scan starts
    wire chk_take; // compare scan starts
    wire period_hit; // period elapsed

    // three-stage capture, level moves once stages two and three agree
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sclk_sync <= 3'h0;
            cs_sync <= 3'h7;
            sclk_f <= 1'b0;
            cs_f <= 1'b1;
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
        end
        else
        begin
            sclk_sync <= {sclk_sync[1:0], spi_sclk_i};
            cs_sync <= {cs_sync[1:0], spi_cs_n_i};
            if (sclk_sync[1] == sclk_sync[2])
            begin
                sclk_f <= sclk_sync[2];
            end
            if (cs_sync[1] == cs_sync[2])
            begin
                cs_f <= cs_sync[2];
            end
            sclk_d <= sclk_f;
            cs_d <= cs_f;
        end
    end

    assign sclk_rise = sclk_f & ~sclk_d;
    assign cs_fall = ~cs_f & cs_d;
    assign cs_rise = cs_f & ~cs_d;

    // serial clock count per framed transfer, saturating
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            bit_cnt <= 6'h00;
        end
        else if (cs_fall)
        begin
            bit_cnt <= 6'h00; // new frame
        end
        else if (sclk_rise && !cs_f && bit_cnt != `DECE_BIT_CNT_MAX)
        begin
            bit_cnt <= bit_cnt + 6'h01;
        end
    end

    // hold the decoded request until the frame closes
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            req_pend <= 1'b0;
            req_wr <= 1'b0;
            req_addr <= 6'h00;
            req_data <= 24'h000000;
            req_len <= 6'h00;
            req_ok <= 1'b0;
            req_ro <= 1'b0;
            req_crc <= 1'b0;
        end
        else if (req_valid_i)
        begin
            req_pend <= 1'b1;
            req_wr <= req_write_i;
            req_addr <= req_addr_i;
            req_data <= req_wdata_i;
            req_len <= req_len_i;
            req_ok <= req_addr_ok_i;
            req_ro <= req_addr_ro_i;
            req_crc <= req_crc_ok_i;
        end
        else if (cs_rise)
        begin
            req_pend <= 1'b0; // consumed at frame end
        end
    end

    assign cnt_armed = err_en_o[`DECE_BIT_CLK_CNT] & chip_select_required_i;
    assign busy = fuse_copy_busy_i | calib_busy_i;
    assign short_frame = cnt_armed & (bit_cnt < req_len);
    assign wr_end = req_pend & req_wr & cs_rise;
    assign rd_end = req_pend & ~req_wr & cs_rise;

    // write passes only if not busy, legal, long enough when the count check is armed, and checksum good when its check is enabled
    assign commit = wr_end & ~busy & ~short_frame & req_ok & ~req_ro
                  & (~err_en_o[`DECE_BIT_CHECKSUM] | req_crc);

    // flag set requests, each gated by its own enable
    always @*
    begin
        set_vec = 8'h00;
        // adc conversion and calibration failures
        set_vec[`DECE_BIT_ADC] = err_en_o[`DECE_BIT_ADC] & adc_check_fail_i;
        // writes during fuse copy or calibration
        set_vec[`DECE_BIT_IGNORE] = err_en_o[`DECE_BIT_IGNORE] & wr_end & busy;
        // frame not a whole number of bytes
        set_vec[`DECE_BIT_CLK_CNT] = cnt_armed & cs_rise
                                   & (bit_cnt[2:0] != `DECE_BITS_PER_BYTE);
        // read of an address that does not exist
        set_vec[`DECE_BIT_READ] = err_en_o[`DECE_BIT_READ] & chip_select_required_i
                                & rd_end & ~req_ok;
        // write to undefined or read-only address
        set_vec[`DECE_BIT_WRITE] = err_en_o[`DECE_BIT_WRITE] & chip_select_required_i
                                 & wr_end & ~busy & ~short_frame
                                 & (~req_ok | req_ro);
        // checksum mismatch on an otherwise good write
        set_vec[`DECE_BIT_CHECKSUM] = err_en_o[`DECE_BIT_CHECKSUM] & wr_end & ~busy
                                    & ~short_frame & req_ok & ~req_ro & ~req_crc;
        // map contents drifted from the reference
        set_vec[`DECE_BIT_MAP_CRC] = map_fault;
        // power-up rom check, reported only when armed
        set_vec[`DECE_BIT_ROM_CRC] = err_en_o[`DECE_BIT_ROM_CRC] & rom_check_done_i
                                   & rom_check_fail_i;
    end

    // sticky flags, a set in the clear cycle survives
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            err_flags_o <= 8'h00;
        end
        else
        begin
            err_flags_o <= (err_flags_o & ~err_clear_i) | set_vec;
        end
    end

    // enable register and committed write outputs
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            err_en_o <= `DECE_ERR_EN_RESET;
            wr_commit_o <= 1'b0;
            wr_addr_o <= 6'h00;
            wr_data_o <= 24'h000000;
        end
        else
        begin
            wr_commit_o <= commit;
            if (commit)
            begin
                wr_addr_o <= req_addr;
                wr_data_o <= req_data;
            end
            if (commit && req_addr == `DECE_ERR_EN_ADDR)
            begin
                err_en_o <= req_data[15:0];
            end
        end
    end

    // legitimate map updates: host write, calibration, idle, streaming exit
    assign map_change = commit | calib_done_i | seq_idle_i
                      | (stream_d & ~streaming_read_i);

    assign period_hit = (per_cnt == MAP_PERIOD_CYC - 14'h0001);
    assign ref_take = ref_req & (st == `DECE_ST_IDLE || st == `DECE_ST_SCAN);
    assign chk_take = chk_req & ~ref_req & (st == `DECE_ST_IDLE);
    assign map_fault = (st == `DECE_ST_DONE) & ~scan_ref & ~ref_req & ref_valid
                     & (crc != ref_crc) & err_en_o[`DECE_BIT_MAP_CRC];

    // period counter for the map check
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            per_cnt <= 14'h0000;
            stream_d <= 1'b0;
        end
        else
        begin
            stream_d <= streaming_read_i;
            if (period_hit)
            begin
                per_cnt <= 14'h0000;
            end
            else
            begin
                per_cnt <= per_cnt + 14'h0001;
            end
        end
    end

    // one word folded into the scan crc
    dece_crc_step u_crc
    (
        .crc_i(crc),
        .data_i(map_rd_data_i),
        .crc_o(crc_next)
    );

    // map scan: rebuild reference or compare against it
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st <= `DECE_ST_IDLE;
            ref_req <= 1'b1; // first reference after reset
            chk_req <= 1'b0;
            scan_ref <= 1'b0;
            issuing <= 1'b0;
            dv <= 1'b0;
            crc <= `DECE_CRC_INIT;
            ref_crc <= 8'h00;
            ref_valid <= 1'b0;
            map_rd_idx_o <= 6'h00;
        end
        else
        begin
            // pending requests, new ones win over the take
            ref_req <= (ref_req & ~ref_take) | map_change;
            chk_req <= (chk_req & ~chk_take) | (period_hit & err_en_o[`DECE_BIT_MAP_CRC]);
            if (ref_take || chk_take)
            begin
                // start or restart a scan from index zero
                st <= `DECE_ST_SCAN;
                scan_ref <= ref_take;
                issuing <= 1'b1;
                dv <= 1'b0;
                crc <= `DECE_CRC_INIT;
                map_rd_idx_o <= 6'h00;
            end
            else
            begin
                case (st)
                    `DECE_ST_IDLE:
                    begin
                        dv <= 1'b0; // nothing to scan
                    end
                    `DECE_ST_SCAN:
                    begin
                        dv <= issuing;
                        if (issuing && map_rd_idx_o == `DECE_MAP_LAST_IDX)
                        begin
                            issuing <= 1'b0; // last index out
                        end
                        else if (issuing)
                        begin
                            map_rd_idx_o <= map_rd_idx_o + 6'h01;
                        end
                        if (dv && map_rd_writable_i)
                        begin
                            crc <= crc_next;
                        end
                        if (!issuing && !dv)
                        begin
                            st <= `DECE_ST_DONE;
                        end
                    end
                    `DECE_ST_DONE:
                    begin
                        // compare happens combinationally here
                        if (scan_ref)
                        begin
                            ref_crc <= crc;
                            ref_valid <= 1'b1;
                        end
                        st <= `DECE_ST_IDLE;
                    end
                    default:
                    begin
                        st <= `DECE_ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // dece_diag_check

// *** dece_regs.vh ***
// Purpose: constants for the diagnostic error-check enable block
// Assumes: 25 MHz core clock, 6-bit register addresses, 24-bit register words
// Notes: bit positions serve both the enable register and the flag vector
`ifndef DECE_REGS_VH
`define DECE_REGS_VH

// enable register location and reset value
`define DECE_ERR_EN_ADDR 6'h07
`define DECE_ERR_EN_RESET 16'h0040

// enable bits, reused as flag positions
`define DECE_BIT_ROM_CRC 0
`define DECE_BIT_MAP_CRC 1
`define DECE_BIT_CHECKSUM 2
`define DECE_BIT_WRITE 3
`define DECE_BIT_READ 4
`define DECE_BIT_CLK_CNT 5
`define DECE_BIT_IGNORE 6
`define DECE_BIT_ADC 7

// serial clock counting
`define DECE_BITS_PER_BYTE 3'h0
`define DECE_BIT_CNT_MAX 6'h3f

// map integrity check timing, period in tenths of a microsecond
`define DECE_CLK_MHZ 25
`define DECE_MAP_PERIOD_US_X10 4266
`define DECE_MAP_PERIOD_CYC (`DECE_MAP_PERIOD_US_X10 * `DECE_CLK_MHZ / 10)

// map scan and crc
`define DECE_MAP_LAST_IDX 6'h3f
`define DECE_CRC_POLY 8'h07
`define DECE_CRC_INIT 8'hff

// scan state codes
`define DECE_ST_IDLE 2'h0
`define DECE_ST_SCAN 2'h1
`define DECE_ST_DONE 2'h2

`endif

// *** dece_crc_step.v ***
// Purpose: one crc-8 update over a full 24-bit register word
// Assumes: msb of the word is shifted in first
// Notes: purely combinational, the caller registers the result
`timescale 1ns/1ps
`include "dece_regs.vh"

module dece_crc_step
(
    // running crc and new word
    input wire [7:0] crc_i,
    input wire [23:0] data_i,
    // updated crc
    output reg [7:0] crc_o
);

    integer i; // bit loop index
    reg fb; // feedback bit
    reg [7:0] c; // working crc

    // bitwise shift of the word through the polynomial
    always @*
    begin
        c = crc_i;
        fb = 1'b0;
        for (i = 23; i >= 0; i = i - 1)
        begin
            fb = c[7] ^ data_i[i];
            c = {c[6:0], 1'b0};
            if (fb)
            begin
                c = c ^ `DECE_CRC_POLY;
            end
        end
        crc_o = c;
    end

endmodule // dece_crc_step

// *** dece_diag_props.sv ***
// Purpose: checker for the diagnostic error-check block
// Assumes: one clock domain, async active-low reset
// Notes: watches top-level ports only
`timescale 1ns/1ps
module dece_diag_props
(
    // clock and reset
    input wire clk_i,
    input wire resetn_i,
    // activity inputs
    input wire fuse_copy_busy_i,
    input wire calib_busy_i,
    input wire adc_check_fail_i,
    input wire rom_check_done_i,
    input wire rom_check_fail_i,
    input wire [7:0] err_clear_i,
    // outputs under watch
    input wire wr_commit_o,
    input wire [5:0] wr_addr_o,
    input wire [23:0] wr_data_o,
    input wire [15:0] err_en_o,
    input wire [7:0] err_flags_o
);
    default clocking dece_cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    AST_ADC_SET: assert property (adc_check_fail_i && err_en_o[7] |=> err_flags_o[7])
        else $error("adc flag not set");
    AST_ADC_GATE: assert property ($rose(err_flags_o[7]) |-> $past(err_en_o[7] && adc_check_fail_i))
        else $error("adc flag set while disarmed");
    AST_ROM_SET: assert property (rom_check_done_i && rom_check_fail_i && err_en_o[0] |=> err_flags_o[0])
        else $error("rom flag not set");
    AST_ROM_GATE: assert property ($rose(err_flags_o[0]) |-> $past(err_en_o[0] && rom_check_fail_i))
        else $error("rom flag set while disarmed");
    AST_EN_RESET: assert property ($rose(resetn_i) |-> err_en_o == 16'h0040)
        else $error("enable reset value wrong");
    AST_EN_WRITE: assert property (wr_commit_o && wr_addr_o == 6'h07 |-> err_en_o == wr_data_o[15:0])
        else $error("enable write not stored");
    AST_EN_HOLD: assert property ($changed(err_en_o) |-> wr_commit_o && wr_addr_o == 6'h07)
        else $error("enable changed without write");
    AST_BUSY_DROP: assert property ($rose(wr_commit_o) |-> !$past(fuse_copy_busy_i | calib_busy_i))
        else $error("write committed while busy");
    AST_FLAG_HOLD: assert property ((($past(err_flags_o) & ~err_flags_o) & ~$past(err_clear_i)) == 8'h00)
        else $error("flag dropped without clear");
    AST_COMMIT_PULSE: assert property (wr_commit_o |=> !wr_commit_o)
        else $error("commit wider than one cycle");

    // main scenarios reached
    cover property ($rose(err_flags_o[5]));
    cover property ($rose(err_flags_o[1]));
    cover property (wr_commit_o && wr_addr_o == 6'h07);
endmodule // dece_diag_props

bind dece_diag_check dece_diag_props u_dece_diag_props
(
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .fuse_copy_busy_i(fuse_copy_busy_i),
    .calib_busy_i(calib_busy_i),
    .adc_check_fail_i(adc_check_fail_i),
    .rom_check_done_i(rom_check_done_i),
    .rom_check_fail_i(rom_check_fail_i),
    .err_clear_i(err_clear_i),
    .wr_commit_o(wr_commit_o),
    .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o),
    .err_en_o(err_en_o),
    .err_flags_o(err_flags_o)
);

// *** dece_spi_host.sv ***
// Purpose: serial host model driving clock and chip select
// Assumes: paced by the core clock, 320 ns serial period
// Notes: serial clock idles low between frames
`timescale 1ns/1ps
module dece_spi_host
(
    // pacing clock
    input wire clk_i,
    // serial pins
    output logic spi_sclk_o,
    output logic spi_cs_n_o
);
    // idle pins
    initial
    begin
        spi_sclk_o = 1'b0;
        spi_cs_n_o = 1'b1;
    end

    // one framed transfer of n pulses
    task frame(input int n);
        begin
            @(negedge clk_i);
            spi_cs_n_o = 1'b0;
            repeat (4) @(negedge clk_i);
            repeat (n)
            begin
                spi_sclk_o = 1'b1;
                repeat (4) @(negedge clk_i);
                spi_sclk_o = 1'b0;
                repeat (4) @(negedge clk_i);
            end
            spi_cs_n_o = 1'b1;
        end
    endtask
endmodule // dece_spi_host

// *** dece_diag_check_bench.sv ***
// Purpose: self-checking bench for the diagnostic error-check block
// Assumes: 25 MHz core clock, short map period
// Notes: table rows first, then hand-written cases
`timescale 1ns/1ps
module dece_diag_check_bench;
    typedef struct packed {
        logic w; logic [5:0] a; logic [23:0] d; logic [5:0] len; logic ok; logic ro;
        logic crc; logic [1:0] busy; logic [5:0] n; logic com; logic [7:0] f;
    } dece_row_t;
    // w addr data len ok ro crc busy clocks commit flags
    dece_row_t rows [0:9] = '{
        '{1, 6'h07, 24'hff, 32, 1, 0, 1, 0, 32, 1, 8'h00},
        '{1, 6'h10, 24'h123456, 32, 1, 0, 1, 0, 32, 1, 8'h00},
        '{1, 6'h05, 24'h1, 32, 1, 1, 1, 0, 32, 0, 8'h08},
        '{1, 6'h3e, 24'h1, 32, 0, 0, 1, 0, 32, 0, 8'h08},
        '{0, 6'h3e, 24'h0, 16, 0, 0, 1, 0, 16, 0, 8'h10},
        '{1, 6'h10, 24'h1, 32, 1, 0, 0, 0, 32, 0, 8'h04},
        '{1, 6'h10, 24'h1, 32, 1, 0, 1, 0, 16, 0, 8'h00},
        '{1, 6'h10, 24'h1, 32, 1, 0, 1, 0, 13, 0, 8'h20},
        '{1, 6'h10, 24'h1, 32, 1, 0, 1, 1, 32, 0, 8'h40},
        '{1, 6'h10, 24'h1, 32, 1, 0, 1, 2, 32, 0, 8'h40}
    };
    logic clk_i, resetn_i, sclk, cs_n, req_valid_i, req_write_i, ok, ro, crc;
    logic fuse, calib, cal_done, adc, rom_done, rom_fail, commit;
    logic [5:0] req_addr_i, req_len_i, idx, wr_addr;
    logic [23:0] req_wdata_i, map_data, map_flip, wr_data;
    logic [15:0] err_en;
    logic [7:0] err_clear_i, flags;
    int mismatches = 0;
    int n_compared = 0;
    int n_commits = 0;

    dece_spi_host u_dece_spi_host (.clk_i(clk_i), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n));
    dece_diag_check #(.MAP_PERIOD_CYC(14'd200)) u_dece_diag_check (
        .clk_i(clk_i), .resetn_i(resetn_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
        .chip_select_required_i(1'b1), .streaming_read_i(1'b0),
        .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .req_len_i(req_len_i), .req_addr_ok_i(ok),
        .req_addr_ro_i(ro), .req_crc_ok_i(crc), .fuse_copy_busy_i(fuse),
        .calib_busy_i(calib), .calib_done_i(cal_done), .seq_idle_i(1'b0),
        .adc_check_fail_i(adc), .rom_check_done_i(rom_done), .rom_check_fail_i(rom_fail),
        .map_rd_idx_o(idx), .map_rd_data_i(map_data), .map_rd_writable_i(1'b1),
        .wr_commit_o(commit), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
        .err_en_o(err_en), .err_clear_i(err_clear_i), .err_flags_o(flags));

    // clock
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // map word for the index shown this cycle, updated on the falling edge
    always @(negedge clk_i)
        map_data <= {18'h0, idx} ^ map_flip;

    // count accepted writes
    always @(posedge clk_i)
        if (commit === 1'b1)
            n_commits++;

    task chk_flags(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t flags %h expected %h", $time, got, exp);
        end
    endtask

    task chk_en(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t enables %h expected %h", $time, got, exp);
        end
    endtask

    task chk_com(input int got, input int exp);
        n_compared++;
        if (got != exp)
        begin
            mismatches++;
            $display("ERROR %0t commits %0d expected %0d", $time, got, exp);
        end
    endtask

    // pulse clear of every flag
    task clear_flags;
        @(negedge clk_i);
        err_clear_i = 8'hff;
        @(negedge clk_i);
        err_clear_i = 8'h00;
    endtask

    // request then framed transfer
    task run_row(input dece_row_t r);
        @(negedge clk_i);
        {fuse, calib} = {r.busy[0], r.busy[1]};
        {req_write_i, req_addr_i, req_wdata_i, req_len_i} = {r.w, r.a, r.d, r.len};
        {ok, ro, crc} = {r.ok, r.ro, r.crc};
        req_valid_i = 1'b1;
        @(negedge clk_i);
        req_valid_i = 1'b0;
        u_dece_spi_host.frame(r.n);
        repeat (10) @(negedge clk_i);
        {fuse, calib} = 2'b00;
    endtask

    // adc and rom failure reports
    task pulse_events;
        @(negedge clk_i);
        {adc, rom_done, rom_fail} = 3'b111;
        @(negedge clk_i);
        {adc, rom_done, rom_fail} = 3'b000;
        repeat (2) @(negedge clk_i);
    endtask

    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog
    initial
    begin
        #2000000;
        mismatches++;
        print_verdict();
    end

    // main sequence
    initial
    begin
        int c0;
        {resetn_i, req_valid_i, req_write_i, ok, ro, crc} = 6'b0;
        {fuse, calib, cal_done, adc, rom_done, rom_fail} = 6'b0;
        {req_addr_i, req_len_i, req_wdata_i, err_clear_i, map_flip} = '0;
        repeat (12) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk_en(err_en, 16'h0040);
        chk_flags(flags, 8'h00);
        for (int i = 0; i < 10; i++)
        begin
            c0 = n_commits;
            run_row(rows[i]);
            chk_com(n_commits - c0, int'(rows[i].com));
            chk_flags(flags, rows[i].f);
            clear_flags();
        end
        chk_en(err_en, 16'h00ff);
        // host reads back the checksummed enable write, no flag, no commit
        c0 = n_commits;
        run_row('{0, 6'h07, 24'h0, 32, 1, 0, 1, 0, 32, 0, 8'h00});
        chk_com(n_commits - c0, 0);
        chk_flags(flags, 8'h00);
        pulse_events();
        chk_flags(flags, 8'h81);
        clear_flags();
        // corrupt the map behind the scan
        map_flip = 24'h000100;
        repeat (500) @(negedge clk_i);
        chk_flags(flags, 8'h02);
        // calibration end rebuilds the reference
        cal_done = 1'b1;
        @(negedge clk_i);
        cal_done = 1'b0;
        repeat (100) @(negedge clk_i);
        clear_flags();
        repeat (500) @(negedge clk_i);
        chk_flags(flags, 8'h00);
        // disarm everything, faults must stay silent
        run_row('{1, 6'h07, 24'h0, 32, 1, 0, 1, 0, 32, 1, 8'h00});
        chk_en(err_en, 16'h0000);
        pulse_events();
        run_row('{1, 6'h10, 24'h1, 32, 1, 0, 1, 1, 13, 0, 8'h00});
        chk_flags(flags, 8'h00);
        print_verdict();
    end
endmodule // dece_diag_check_bench
